//--- design/scc_sci_ctrl.sv
// Contract
// RULE1 - Ninth rx bit stored with rx data
// RULE2 - Ninth tx bit loaded into shifter
// RULE3 - One format bit sets 8/9 data
// RULE4 - Wake method gates receive full
// RULE5 - Wake select writable at any time
// RULE6 - Clock pin rests at polarity
// RULE7 - Phase picks bit start or middle
// RULE8 - Last bit clock only if enabled
// RULE9 - Software sets clock options before enable
// RULE10 - Four enables gate interrupt sources
// RULE11 - Enabled transmitter drives data, clock
// RULE12 - Preamble of ones on enable
// RULE13 - Disable finishes byte, then tristate
// RULE14 - Re-enable finishes byte, new preamble
// RULE15 - Software disables after last empty flag
// RULE16 - Disabled receiver sets no flags
// RULE17 - Sleep blocks new flags, keeps old
// RULE18 - Idle wake clears sleep; idle ignores
// RULE19 - Address mark clears sleep, delivers
// RULE20 - Break sends whole blocks of zeros
// RULE21 - High bit after each break
// RULE22 - No clock outside data bits
// RULE23 - One combined interrupt request
//
// The address-and-strobe port was left to the implementer.
`timescale 1ns/1ns
`default_nettype none

module scc_sci_ctrl #(
  parameter int BIT_CYC = scc_pkg::BIT_CYC   // Mclk cycles per bit
) (
  input  wire logic             mclk,         // System clock
  input  wire logic             reset,        // Sync reset, high
  input  wire scc_pkg::scc_bus_t bus,         // Register request
  output logic [7:0]            rdata,        // Read data, next cycle
  input  wire logic             rx_data_pin,  // Serial receive pin
  output logic                  txd,          // Tx pin level
  output logic                  txd_oe,       // Tx pin enable
  output logic                  sclk,         // Clock pin level
  output logic                  sclk_oe,      // Clock pin enable
  output logic                  irq           // Interrupt request
);

  // ****************************************
  // Derived values
  // ****************************************
  localparam logic [15:0] BC   = 16'(BIT_CYC);      // Bit time
  localparam logic [15:0] HALF = 16'(BIT_CYC / 2);  // Mid bit

  scc_pkg::scc_st_t q;         // Registered state
  scc_pkg::scc_st_t n;         // Next state
  logic [3:0]       flen;      // Frame length
  logic [3:0]       ndat;      // Data bits
  logic [15:0]      idle_lim;  // Idle time in cycles
  logic             line_idle; // Line idle now
  logic             vote;      // Majority sample
  logic             noisy;     // Samples disagree
  logic             tend;      // Tx unit ends
  logic             msb;       // Address mark bit
  logic             sclk_act;  // Clock pulse phase

  // ****************************************
  // Frame geometry and sample voting
  // ****************************************
  // RULE3 format sets length
  assign flen      = q.c1[scc_pkg::C1_FMT] ? scc_pkg::LEN9 : scc_pkg::LEN8;
  assign ndat      = flen - 4'h2;
  assign idle_lim  = 16'({12'h000, flen} * BC);
  assign line_idle = (q.icnt >= idle_lim);
  // Two of three samples decide a bit
  assign vote      = (q.hist[0] & q.hist[1]) | (q.hist[0] & q.hist[2])
                   | (q.hist[1] & q.hist[2]);
  // Any disagreement marks noise
  assign noisy     = !(&q.hist) && (|q.hist);
  // Last cycle of a unit's last bit
  assign tend      = (q.ts == scc_pkg::TX_SHIFT) && (q.tbc == BC - 16'h0001)
                   && (q.tbit == q.tlen - 4'h1);
  // Wake mark is the top data bit
  assign msb       = q.c1[scc_pkg::C1_FMT] ? q.rsh[8] : q.rsh[7];

  // ****************************************
  // Next state
  // ****************************************
  always_comb
  begin
    // Hold every field unless a branch moves it
    n        = q;
    sclk_act = 1'b0;
    // Read data stands one cycle only
    n.rdata  = 8'h00;
    // Pin passes two flops before use
    n.sync   = {q.sync[0], rx_data_pin};
    n.hist   = {q.hist[1:0], q.sync[1]};

    // Register reads
    if (bus.rd)
    begin
      unique case (bus.addr)
        scc_pkg::ADR_CTRL1: n.rdata = q.c1;
        scc_pkg::ADR_CTRL2: n.rdata = q.c2;
        scc_pkg::ADR_STAT:
        begin
          n.rdata = {q.tx_reg_empty_flag, q.tc, q.rx_reg_full_flag, q.idle, q.ovr, q.nf, q.fe, 1'b0};
          n.seen  = 1'b1;
        end
        scc_pkg::ADR_DATA:
        begin
          n.rdata = q.rdr;
          // Status then data read clears rx flags
          if (q.seen)
          begin
            n.rx_reg_full_flag = 1'b0;
            n.idle = 1'b0;
            n.ovr  = 1'b0;
            n.nf   = 1'b0;
            n.fe   = 1'b0;
            n.seen = 1'b0;
          end
        end
        default: n.rdata = 8'h00;  // Unmapped reads zero
      endcase
    end

    // Register writes
    if (bus.wr)
    begin
      unique case (bus.addr)
        scc_pkg::ADR_CTRL1:
          // RULE5 wake select writable
          n.c1 = {q.c1[7], bus.wdata[6], 1'b0, bus.wdata[4:0]};
        scc_pkg::ADR_CTRL2:
        begin
          n.c2 = bus.wdata;
          // RULE12 enable rising owes preamble
          if (bus.wdata[scc_pkg::C2_TE] && !q.c2[scc_pkg::C2_TE])
            n.pend = 1'b1;
          // RULE18 sleep refused on idle line
          if (bus.wdata[scc_pkg::C2_SLP] && !q.c2[scc_pkg::C2_SLP]
              && !q.c1[scc_pkg::C1_WAKE] && line_idle)
            n.c2[scc_pkg::C2_SLP] = 1'b0;
        end
        scc_pkg::ADR_DATA:
        begin
          n.tdr = bus.wdata;
          // Status then data write clears tx flags
          if (q.seen)
          begin
            n.tx_reg_empty_flag = 1'b0;
            n.tc   = 1'b0;
            n.seen = 1'b0;
          end
        end
        default: ;  // Unmapped writes ignored
      endcase
    end

    // ****************************************
    // Transmitter
    // ****************************************
    // Bit timer and shifter advance per bit
    if (q.ts == scc_pkg::TX_SHIFT)
    begin
      n.tbc = q.tbc + 16'h0001;
      if (q.tbc == BC - 16'h0001)
      begin
        n.tbc  = 16'h0000;
        n.tbit = q.tbit + 4'h1;
        // Ones fill behind so the line marks
        n.tsh  = {1'b1, q.tsh[11:1]};
      end
    end

    // Choose next unit at idle or unit end
    // Priority: disable, preamble, break, mark, data
    if (q.ts == scc_pkg::TX_IDLE || tend)
    begin
      n.ts   = scc_pkg::TX_SHIFT;
      n.tbc  = 16'h0000;
      n.tbit = 4'h0;
      n.tlen = flen;
      // RULE13 finish unit then release pins
      if (!q.c2[scc_pkg::C2_TE])
      begin
        n.ts   = scc_pkg::TX_IDLE;
        n.kind = scc_pkg::K_DATA;
      end
      // RULE14 re-enable sends new preamble
      else if (q.pend)
      begin
        n.kind = scc_pkg::K_PRE;
        n.tsh  = 12'hfff;
        n.pend = 1'b0;
      end
      // RULE20 break blocks while set
      else if (q.c2[scc_pkg::C2_BRK])
      begin
        n.kind = scc_pkg::K_BRK;
        n.tsh  = 12'h000;
      end
      // RULE21 mark bit after break
      else if (q.ts == scc_pkg::TX_SHIFT && q.kind == scc_pkg::K_BRK)
      begin
        n.kind = scc_pkg::K_MARK;
        n.tsh  = 12'hfff;
        n.tlen = 4'h1;
      end
      else if (!q.tx_reg_empty_flag)
      begin
        n.kind = scc_pkg::K_DATA;
        n.tx_reg_empty_flag = 1'b1;
        // Start low, data, ninth or stop, stop
        // RULE2 ninth bit into shifter
        if (q.c1[scc_pkg::C1_FMT])
          n.tsh = {1'b1, 1'b1, q.c1[scc_pkg::C1_TX9], q.tdr, 1'b0};
        else
          n.tsh = {1'b1, 1'b1, 1'b1, q.tdr, 1'b0};
      end
      else
      begin
        n.ts   = scc_pkg::TX_IDLE;
        n.kind = scc_pkg::K_DATA;
        // Nothing to send: mark and report done
        n.tc   = 1'b1;
      end
    end

    // RULE22 clock only on data bits
    if (n.ts == scc_pkg::TX_SHIFT && n.kind == scc_pkg::K_DATA
        && n.tbit != 4'h0 && n.tbit <= ndat)
    begin
      // RULE8 last bit clock option
      if (n.tbit != ndat || q.c1[scc_pkg::C1_LBC])
        // RULE7 pulse at start or middle
        sclk_act = q.c1[scc_pkg::C1_PHA] ? (n.tbc < HALF) : (n.tbc >= HALF);
    end

    // Pins held until the last unit leaves
    // RULE11 pins driven while enabled
    n.txd_oe  = n.c2[scc_pkg::C2_TE] || (n.ts == scc_pkg::TX_SHIFT);
    n.sclk_oe = n.txd_oe;
    n.txd     = (n.ts == scc_pkg::TX_SHIFT) ? n.tsh[0] : 1'b1;
    // RULE6 rest level follows polarity
    n.sclk    = q.c1[scc_pkg::C1_POL] ^ sclk_act;

    // ****************************************
    // Receiver
    // ****************************************
    // RULE16 disabled receiver sets nothing
    if (!q.c2[scc_pkg::C2_RE])
    begin
      n.rs   = scc_pkg::RX_IDLE;
      n.icnt = 16'h0000;
    end
    else
    begin
      unique case (q.rs)
        scc_pkg::RX_IDLE:
        begin
          n.rbc = 16'h0000;
          // Count high time, saturating at idle
          n.icnt = q.sync[1] ? (line_idle ? q.icnt : q.icnt + 16'h0001) : 16'h0000;
          // Idle time reached this cycle
          if (q.sync[1] && q.icnt == idle_lim - 16'h0001)
          begin
            // RULE18 idle wake clears sleep
            if (q.c2[scc_pkg::C2_SLP] && !q.c1[scc_pkg::C1_WAKE])
              n.c2[scc_pkg::C2_SLP] = 1'b0;
            // RULE17 asleep sets no idle
            else if (!q.c2[scc_pkg::C2_SLP] && q.armed)
            begin
              n.idle  = 1'b1;
              n.armed = 1'b0;
            end
          end
          // Falling line opens a frame
          if (!q.sync[1])
            n.rs = scc_pkg::RX_START;
        end
        scc_pkg::RX_START, scc_pkg::RX_BITS:
        begin
          n.icnt = 16'h0000;
          // Bit timer wraps each bit time
          n.rbc  = (q.rbc == BC - 16'h0001) ? 16'h0000 : q.rbc + 16'h0001;
          // Sample once history spans mid bit
          if (q.rbc == HALF + 16'h0001)
          begin
            if (q.rs == scc_pkg::RX_START)
            begin
              // Majority high is a false start
              n.rs   = vote ? scc_pkg::RX_IDLE : scc_pkg::RX_BITS;
              n.nfw  = noisy;
              n.rbit = 4'h0;
            end
            else if (q.rbit != ndat)
            begin
              n.rsh[q.rbit] = vote;
              n.nfw         = q.nfw | noisy;
              n.rbit        = q.rbit + 4'h1;
            end
            else
            begin
              // Stop bit sampled, frame ends
              n.rs = scc_pkg::RX_IDLE;
              // RULE19 address mark wakes receiver
              if (q.c2[scc_pkg::C2_SLP] && q.c1[scc_pkg::C1_WAKE] && msb)
                n.c2[scc_pkg::C2_SLP] = 1'b0;
              // RULE4 RULE17 deliver only when awake
              if (!q.c2[scc_pkg::C2_SLP]
                  || (q.c1[scc_pkg::C1_WAKE] && msb))
              begin
                // Overrun keeps the held byte
                if (q.rx_reg_full_flag)
                  n.ovr = 1'b1;
                // Framing error blocks new transfers
                else if (!q.fe)
                begin
                  n.rdr   = q.rsh[7:0];
                  // RULE1 ninth bit with data
                  n.c1[scc_pkg::C1_RX9] = q.rsh[8];
                  n.rx_reg_full_flag  = 1'b1;
                  n.fe    = !vote;
                  n.nf    = q.nfw | noisy;
                  n.armed = 1'b1;
                end
              end
            end
          end
        end
        default: n.rs = scc_pkg::RX_IDLE;
      endcase
    end

    // Level request, registered with flags
    // RULE10 RULE23 gated sources combined
    n.irq = (n.tx_reg_empty_flag & n.c2[scc_pkg::C2_TXEI]) | (n.tc & n.c2[scc_pkg::C2_TCI])
          | ((n.rx_reg_full_flag | n.ovr) & n.c2[scc_pkg::C2_RXI])
          | (n.idle & n.c2[scc_pkg::C2_ILI]);
  end

  // ****************************************
  // State register
  // ****************************************
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      q      <= '0;
      q.c1   <= scc_pkg::CTRL1_RST;
      q.c2   <= scc_pkg::CTRL2_RST;
      q.tx_reg_empty_flag <= scc_pkg::TX_REG_EMPTY_FLAG_RST;
      q.tc   <= scc_pkg::TC_RST;
      // Synchroniser starts at line idle
      q.sync <= 2'h3;
      q.hist <= 3'h7;
      q.txd  <= 1'b1;
    end
    else
      q <= n;
  end

  // ****************************************
  // Outputs straight from the state register
  // ****************************************
  assign rdata   = q.rdata;
  assign txd     = q.txd;
  assign txd_oe  = q.txd_oe;
  assign sclk    = q.sclk;
  assign sclk_oe = q.sclk_oe;
  assign irq     = q.irq;

endmodule : scc_sci_ctrl

`default_nettype wire

//--- inc/scc_pkg.sv
package scc_pkg;

  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [7:0] ADR_CTRL1 = 8'h0e;  // Serial control one
  localparam logic [7:0] ADR_CTRL2 = 8'h0f;  // Serial control two
  localparam logic [7:0] ADR_STAT  = 8'h10;  // Status flags
  localparam logic [7:0] ADR_DATA  = 8'h11;  // Tx write / rx read data

  // ****************************************
  // Field positions
  // ****************************************
  localparam int C1_RX9  = 7;  // Received ninth bit, read only
  localparam int C1_TX9  = 6;  // Ninth bit to send
  localparam int C1_FMT  = 4;  // Nine data bit format
  localparam int C1_WAKE = 3;  // Wake on address mark
  localparam int C1_POL  = 2;  // Clock rest level
  localparam int C1_PHA  = 1;  // Clock at bit start
  localparam int C1_LBC  = 0;  // Clock on last data bit
  localparam int C2_TXEI = 7;  // Tx empty irq enable
  localparam int C2_TCI  = 6;  // Tx done irq enable
  localparam int C2_RXI  = 5;  // Rx full / overrun irq enable
  localparam int C2_ILI  = 4;  // Idle irq enable
  localparam int C2_TE   = 3;  // Transmitter enable
  localparam int C2_RE   = 2;  // Receiver enable
  localparam int C2_SLP  = 1;  // Receiver sleep
  localparam int C2_BRK  = 0;  // Send break

  // ****************************************
  // Reset values and counts
  // ****************************************
  localparam logic [7:0] CTRL1_RST = 8'h00;  // Control one after reset
  localparam logic [7:0] CTRL2_RST = 8'h00;  // Control two after reset
  localparam logic       TX_REG_EMPTY_FLAG_RST  = 1'b1;   // Tx register empty
  localparam logic       TC_RST    = 1'b1;   // Tx complete
  localparam logic [3:0] LEN8      = 4'ha;   // Frame bits, 8 bit format
  localparam logic [3:0] LEN9      = 4'hb;   // Frame bits, 9 bit format
  localparam int         BIT_CYC   = 16;     // Mclk cycles per bit

  // ****************************************
  // Types
  // ****************************************
  typedef struct packed {
    logic [7:0] addr;   // Register offset
    logic [7:0] wdata;  // Write data
    logic       wr;     // Write strobe
    logic       rd;     // Read strobe
  } scc_bus_t;

  typedef enum logic {TX_IDLE, TX_SHIFT} scc_tx_st_t;
  typedef enum logic [1:0] {K_DATA, K_PRE, K_BRK, K_MARK} scc_kind_t;
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_BITS} scc_rx_st_t;

  typedef struct packed {
    logic [7:0]  c1;      // Serial control one
    logic [7:0]  c2;      // Serial control two
    logic        tx_reg_empty_flag;    // Tx register empty
    logic        tc;      // Tx complete
    logic        rx_reg_full_flag;    // Rx register full
    logic        idle;    // Idle line seen
    logic        ovr;     // Overrun
    logic        nf;      // Noise
    logic        fe;      // Framing error
    logic        seen;    // Status read armed
    logic        armed;   // Idle flag may set
    logic        pend;    // Preamble owed
    logic [7:0]  tdr;     // Tx data register
    logic [7:0]  rdr;     // Rx data register
    scc_tx_st_t  ts;      // Tx state
    scc_kind_t   kind;    // Unit being shifted
    logic [11:0] tsh;     // Tx shifter
    logic [3:0]  tbit;    // Tx bit index
    logic [3:0]  tlen;    // Tx unit length
    logic [15:0] tbc;     // Tx bit timer
    logic [1:0]  sync;    // Rx pin synchroniser
    logic [2:0]  hist;    // Rx sample history
    scc_rx_st_t  rs;      // Rx state
    logic [15:0] rbc;     // Rx bit timer
    logic [3:0]  rbit;    // Rx bit index
    logic [9:0]  rsh;     // Rx shifter
    logic        nfw;     // Working noise
    logic [15:0] icnt;    // Idle line timer
    logic [7:0]  rdata;   // Read data out
    logic        txd;     // Tx pin level
    logic        txd_oe;  // Tx pin enable
    logic        sclk;    // Clock pin level
    logic        sclk_oe; // Clock pin enable
    logic        irq;     // Combined irq
  } scc_st_t;

endpackage : scc_pkg

//--- sim/scc_remote.sv
`timescale 1ns/1ns
`default_nettype none
// ********
// Remote serial station
// ********
module scc_remote #(
  parameter int BC = 8  // Mclk cycles per bit
) (
  input wire logic mclk,  // Clock
  input wire logic txd,   // Block tx level
  input wire logic sclk,  // Block clock level
  output var logic rxd    // Line into block
);
  initial rxd = 1'b1;  // Idle mark from time zero

  // Send start, nine data bits, stop
  task automatic send(input logic [8:0] d, input logic stp);
    logic [10:0] f;
    f = {stp, d, 1'b0};
    for (int i = 0; i < 11; i++)
    begin
      @(posedge mclk);
      rxd <= f[i];
      repeat (BC - 1) @(posedge mclk);
    end
    @(posedge mclk);
    rxd <= 1'b1;
  endtask : send

  // Catch one frame, count clocks, note phase
  task automatic grab(input int n, output logic [10:0] b, output int w, output int p,
                      output logic ph);
    logic ps;
    b = '0;
    w = 0;
    p = 0;
    ph = 1'b0;
    while (txd !== 1'b0 && w < 4000)
    begin
      @(negedge mclk);
      w++;
    end
    ps = sclk;
    for (int i = 0; i < n * BC; i++)
    begin
      if (i % BC == BC / 2) b[i / BC] = txd;
      if (i == BC + 2) ph = sclk;
      if (sclk !== ps) p++;
      ps = sclk;
      @(negedge mclk);
    end
    p = p / 2;
  endtask : grab
endmodule : scc_remote
`default_nettype wire

//--- sim/scc_sci_ctrl_asserts.sv
`timescale 1ns/1ns
`default_nettype none
// ********
// Port checker
// ********
module scc_sci_ctrl_asserts #(
  parameter int BIT_CYC = 16  // Mclk cycles per bit
) (
  input wire logic              mclk,         // Clock
  input wire logic              reset,        // Sync reset
  input wire scc_pkg::scc_bus_t bus,          // Register request
  input wire logic [7:0]        rdata,        // Read data
  input wire logic              rx_data_pin,  // Serial in
  input wire logic              txd,          // Tx level
  input wire logic              txd_oe,       // Tx enable
  input wire logic              sclk,         // Clock level
  input wire logic              sclk_oe,      // Clock enable
  input wire logic              irq           // Interrupt
);
  localparam int PRE = 10 * BIT_CYC - 1;  // Shortest preamble
  logic [7:0] c1_q;  // Snooped control one
  logic [7:0] c2_q;  // Snooped control two

  // Follow software writes
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      c1_q <= 8'h00;
      c2_q <= 8'h00;
    end
    else if (bus.wr && bus.addr == scc_pkg::ADR_CTRL1)
      c1_q <= bus.wdata;
    else if (bus.wr && bus.addr == scc_pkg::ADR_CTRL2)
      c2_q <= bus.wdata;
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  // Ones with a quiet clock
  sequence pre_s;
    (txd && $stable(sclk)) throughout ##PRE 1;
  endsequence

  pre_ones_a: assert property ($rose(txd_oe) |-> pre_s)
    else $error("preamble missing on tx enable");
  oe_pair_a: assert property (sclk_oe == txd_oe)
    else $error("pin enables differ");
  oe_cause_a: assert property ($rose(txd_oe) |-> c2_q[3])
    else $error("pins enabled without tx enable");
  stop_end_a: assert property ($fell(txd_oe) |-> $past(txd) && !c2_q[3])
    else $error("pins released mid unit");
  rest_lvl_a: assert property (!txd_oe && $past(c1_q[2], 3) == c1_q[2] |-> sclk == c1_q[2])
    else $error("clock pin off rest level");
  wake_rd_a: assert property (bus.rd && bus.addr == scc_pkg::ADR_CTRL1 |=>
    !rdata[5] && rdata[3:0] == $past(c1_q[3:0]))
    else $error("control one read back wrong");
  ctrl2_rd_a: assert property (bus.rd && bus.addr == scc_pkg::ADR_CTRL2 |=>
    (rdata & 8'hfd) == ($past(c2_q) & 8'hfd))
    else $error("control two read back wrong");
  irq_gate_a: assert property (c2_q[7:4] == 4'h0 && $past(c2_q[7:4]) == 4'h0
    |-> !irq)
    else $error("irq with all enables clear");
endmodule : scc_sci_ctrl_asserts

bind scc_sci_ctrl scc_sci_ctrl_asserts #(.BIT_CYC(BIT_CYC)) chk_u (
  .mclk(mclk), .reset(reset), .bus(bus), .rdata(rdata), .rx_data_pin(rx_data_pin),
  .txd(txd), .txd_oe(txd_oe), .sclk(sclk), .sclk_oe(sclk_oe), .irq(irq)
);
`default_nettype wire

//--- sim/scc_sci_ctrl_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module scc_sci_ctrl_tb_top;
  localparam int BC = 8;          // Short bit time
  logic              mclk  = 1'b0;  // Clock
  logic              reset = 1'b1;  // Reset
  scc_pkg::scc_bus_t bus   = '0;    // Register request
  logic [7:0]        rdata;         // Read data
  logic              rxd, txd, txd_oe, sclk, sclk_oe, irq;  // Pins
  int                err_total  = 0;  // Mismatches
  int                n_compared = 0;  // Comparisons

  always #5 mclk = ~mclk;

  scc_sci_ctrl #(.BIT_CYC(BC)) dut_u (
    .mclk(mclk), .reset(reset), .bus(bus), .rdata(rdata), .rx_data_pin(rxd),
    .txd(txd), .txd_oe(txd_oe), .sclk(sclk), .sclk_oe(sclk_oe), .irq(irq)
  );
  scc_remote #(.BC(BC)) partner_u (.mclk(mclk), .txd(txd), .sclk(sclk), .rxd(rxd));

  // ********
  // Shared tasks
  // ********
  task automatic chk(input string nm, input logic [15:0] s, input logic [15:0] e);
    n_compared++;
    if (s !== e)
    begin
      err_total++;
      $display("mismatch %s expected %h seen %h", nm, e, s);
    end
  endtask : chk

  task automatic stop_test;
    $display("errors %0d, compared %0d", err_total, n_compared);
    if (err_total == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : stop_test

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge mclk);
    bus.wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge mclk);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge mclk);
    bus.rd <= 1'b0;
    #1 d = rdata;
  endtask : rd

  // Bounded wait for a tx level
  task automatic until_txd(input logic v);
    int k;
    k = 0;
    while (txd !== v)
    begin
      if (k == 4000)
      begin
        err_total++;
        stop_test;
      end
      @(negedge mclk);
      k++;
    end
  endtask : until_txd

  // ********
  // Scenarios
  // ********
  task automatic t_reset;
    logic [7:0] ad [4] = '{scc_pkg::ADR_CTRL1, scc_pkg::ADR_CTRL2, scc_pkg::ADR_STAT, 8'h20};
    logic [7:0] ev [4] = '{8'h00, 8'h00, 8'hc0, 8'h00};
    logic [7:0] s;
    for (int i = 0; i < 4; i++)
    begin
      rd(ad[i], s);
      chk("reset value", 16'(s), 16'(ev[i]));
    end
    wr(scc_pkg::ADR_CTRL1, 8'hef);
    rd(scc_pkg::ADR_CTRL1, s);
    chk("ctrl1 rw", 16'(s), 16'h004f);
    wr(scc_pkg::ADR_CTRL1, 8'h00);
  endtask : t_reset

  task automatic t_irq;
    logic [7:0] en [5] = '{8'h80, 8'h40, 8'h20, 8'h10, 8'h00};
    logic       ex [5] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b0};
    for (int i = 0; i < 5; i++)
    begin
      wr(scc_pkg::ADR_CTRL2, en[i]);
      repeat (3) @(negedge mclk);
      chk("irq", 16'(irq), 16'(ex[i]));
    end
  endtask : t_irq

  task automatic t_tx;
    logic [7:0]  c1s [2] = '{8'h04, 8'h57};
    logic [7:0]  dat [2] = '{8'ha5, 8'h3c};
    logic [10:0] b;
    logic [7:0]  s;
    logic        ph;
    int          w, p, n;
    for (int i = 0; i < 2; i++)
    begin
      n = 10 + i;
      wr(scc_pkg::ADR_CTRL1, c1s[i]);
      wr(scc_pkg::ADR_CTRL2, 8'h08);
      rd(scc_pkg::ADR_STAT, s);
      wr(scc_pkg::ADR_DATA, dat[i]);
      fork
        partner_u.grab(n, b, w, p, ph);
        begin
          until_txd(1'b0);
          wr(scc_pkg::ADR_CTRL2, 8'h00);
        end
      join
      chk("frame", 16'(b), 16'({i == 1, 1'b1, dat[i], 1'b0}));
      chk("clocks", 16'(p), 16'(7 + 2 * i));
      chk("phase", 16'(ph), 16'(1 - i));
      chk("preamble", 16'(w >= n * BC - 8 && w <= n * BC + BC), 16'h0001);
      repeat (4) @(negedge mclk);
      chk("tx oe", 16'(txd_oe), 16'h0000);
      chk("clk rest", 16'(sclk), 16'h0001);
    end
  endtask : t_tx

  task automatic t_brk;
    int k, m;
    k = 0;
    m = 0;
    wr(scc_pkg::ADR_CTRL2, 8'h09);
    until_txd(1'b0);
    fork
      wr(scc_pkg::ADR_CTRL2, 8'h08);
      while (txd === 1'b0 && k < 400)
      begin
        @(negedge mclk);
        k++;
      end
    join
    chk("break len", 16'(k), 16'(11 * BC));
    repeat (BC)
    begin
      if (txd !== 1'b1) m++;
      @(negedge mclk);
    end
    chk("mark", 16'(m), 16'h0000);
    wr(scc_pkg::ADR_CTRL2, 8'h00);
  endtask : t_brk

  task automatic t_rx;
    logic [7:0] c2s [6] = '{8'h04, 8'h04, 8'h00, 8'h06, 8'h06, 8'h04};
    logic [8:0] dv  [6] = '{9'h05a, 9'h1c3, 9'h0aa, 9'h011, 9'h177, 9'h066};
    logic [7:0] es  [6] = '{8'h20, 8'h20, 8'h00, 8'h00, 8'h20, 8'h22};
    logic [7:0] ed  [6] = '{8'h5a, 8'hc3, 8'hc3, 8'hc3, 8'h77, 8'h66};
    logic [7:0] e2  [6] = '{8'h04, 8'h04, 8'h00, 8'h06, 8'h04, 8'h04};
    logic [7:0] s;
    for (int i = 0; i < 6; i++)
    begin
      wr(scc_pkg::ADR_CTRL1, (i == 3 || i == 4) ? 8'h18 : 8'h10);
      wr(scc_pkg::ADR_CTRL2, c2s[i]);
      partner_u.send(dv[i], i != 5);
      rd(scc_pkg::ADR_STAT, s);
      chk("rx status", 16'(s & 8'h2e), 16'(es[i]));
      rd(scc_pkg::ADR_DATA, s);
      chk("rx data", 16'(s), 16'(ed[i]));
      rd(scc_pkg::ADR_CTRL1, s);
      chk("rx ninth", 16'(s[7]), 16'(dv[i][8] | (i == 2 || i == 3)));
      rd(scc_pkg::ADR_CTRL2, s);
      chk("sleep", 16'(s), 16'(e2[i]));
    end
  endtask : t_rx

  task automatic t_wake;
    logic [7:0] s;
    wr(scc_pkg::ADR_CTRL1, 8'h10);
    wr(scc_pkg::ADR_CTRL2, 8'h04);
    repeat (100) @(posedge mclk);
    wr(scc_pkg::ADR_CTRL2, 8'h06);
    rd(scc_pkg::ADR_CTRL2, s);
    chk("sleep on idle", 16'(s), 16'h0004);
    fork
      partner_u.send(9'h0a5, 1'b1);
      begin
        repeat (20) @(posedge mclk);
        wr(scc_pkg::ADR_CTRL2, 8'h06);
      end
    join
    rd(scc_pkg::ADR_STAT, s);
    chk("asleep status", 16'(s & 8'h2e), 16'h0000);
    rd(scc_pkg::ADR_CTRL2, s);
    chk("asleep", 16'(s), 16'h0006);
    repeat (100) @(posedge mclk);
    rd(scc_pkg::ADR_CTRL2, s);
    chk("idle wake", 16'(s), 16'h0004);
    partner_u.send(9'h03c, 1'b1);
    rd(scc_pkg::ADR_STAT, s);
    chk("woken status", 16'(s & 8'h2e), 16'h0020);
    rd(scc_pkg::ADR_DATA, s);
    chk("woken data", 16'(s), 16'h003c);
  endtask : t_wake

  // Main sequence
  initial
  begin
    repeat (16) @(posedge mclk);
    reset <= 1'b0;
    t_reset;
    t_irq;
    t_tx;
    t_brk;
    t_rx;
    t_wake;
    stop_test;
  end
endmodule : scc_sci_ctrl_tb_top
`default_nettype wire
